// *** logic/psi_params.svh ***
/*
 * Constants of the pseudo-static RAM pin interface: widths, field positions,
 * reset values and the fixed burst latency.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef PSI_PARAMS_SVH
`define PSI_PARAMS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define PSI_AW            22
`define PSI_DW            16
`define PSI_LAT_W         3

// ----------------------------------------------------------------------------
// Configuration register layout and reset values
// ----------------------------------------------------------------------------
`define PSI_CFG_LOAD_MSB  15
`define PSI_SEL_BCR_BIT   19
`define PSI_SEL_ID_BIT    18
`define PSI_MODE_MSB      1
`define PSI_MODE_LSB      0
`define PSI_BCR_RESET     16'h0000
`define PSI_RCR_RESET     16'h0000
`define PSI_DEVICE_ID     16'h5a5a

// ----------------------------------------------------------------------------
// Timing, in host clock rising edges
// ----------------------------------------------------------------------------
`define PSI_BURST_LATENCY 3'h3

`endif

// *** logic/psi_pkg.sv ***
/*
 * Types shared by the pin interface and its configuration registers.
 * Assumes psi_params.svh is on the include path.
 */
`include "psi_params.svh"

package psi_pkg;

    // Bus protocol held in the low bits of the bus configuration register
    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_NOR   = 2'h1,
        MODE_SYNC  = 2'h2,
        MODE_RSVD  = 2'h3
    } psi_mode_type;

    // Control interface states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARD,
        ST_AWR,
        ST_CWR,
        ST_BRD,
        ST_BWR
    } psi_state_type;

    // Which control register an access targets
    typedef enum logic [1:0] {
        CFG_RCR,
        CFG_BCR,
        CFG_ID
    } psi_cfg_sel_type;

    // Register select from the two address bits; the ID bit wins
    function automatic psi_cfg_sel_type cfg_sel(input logic a_bcr, input logic a_id);
        psi_cfg_sel_type s;
        s = CFG_RCR;
        if (a_id)
            s = CFG_ID;
        else if (a_bcr)
            s = CFG_BCR;
        return s;
    endfunction

endpackage

// *** logic/psi_mem.sv ***
/*
 * Word-wide array with two byte write enables and a registered read port.
 * Assumes one clock and that write and read addresses are already decoded.
 */
`timescale 1ns/10ps
`include "psi_params.svh"

module psi_mem
(
    input  wire logic                 core_clk,
    input  wire logic [1:0]           wr_bytes,
    input  wire logic [`PSI_AW-1:0]   wr_addr,
    input  wire logic [`PSI_DW-1:0]   wr_data,
    input  wire logic [`PSI_AW-1:0]   rd_addr,
    output logic      [`PSI_DW-1:0]   rd_data
);

    logic [`PSI_DW-1:0] mem_q [0:(1<<`PSI_AW)-1];

    // Byte lanes written separately so a masked byte keeps its old value
    always_ff @(posedge core_clk)
    begin
        if (wr_bytes[1])
            mem_q[wr_addr][15:8] <= wr_data[15:8];
        if (wr_bytes[0])
            mem_q[wr_addr][7:0] <= wr_data[7:0];
        rd_data <= mem_q[rd_addr];
    end

endmodule

// *** logic/psi_cfg_regs.sv ***
/*
 * Refresh and bus configuration registers plus a read-only identity word.
 * Assumes the caller issues a load only while the interface is idle.
 */
`timescale 1ns/10ps
`include "psi_params.svh"

module psi_cfg_regs
#(
    parameter logic [15:0] DEVICE_ID = `PSI_DEVICE_ID  // Arbitrary value
)
(
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic                 load,
    input  wire logic [`PSI_AW-1:0]   addr,
    output logic      [`PSI_DW-1:0]   rd_data,
    output logic      [`PSI_DW-1:0]   bcr
);

    logic [`PSI_DW-1:0]    rcr_q;
    logic [`PSI_DW-1:0]    bcr_q;
    psi_pkg::psi_cfg_sel_type sel;

    assign sel = psi_pkg::cfg_sel(addr[`PSI_SEL_BCR_BIT], addr[`PSI_SEL_ID_BIT]);
    assign bcr = bcr_q;

    // Read select; the identity word is fixed
    assign rd_data = (sel == psi_pkg::CFG_ID)  ? DEVICE_ID :
                     (sel == psi_pkg::CFG_BCR) ? bcr_q : rcr_q;

    // Load from the address bus, so a write needs no data phase
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rcr_q <= `PSI_RCR_RESET;
            bcr_q <= `PSI_BCR_RESET;
        end
        else if (load && sel == psi_pkg::CFG_BCR)
            bcr_q <= addr[`PSI_CFG_LOAD_MSB:0];
        else if (load && sel == psi_pkg::CFG_RCR)
            rcr_q <= addr[`PSI_CFG_LOAD_MSB:0];
    end

endmodule

// *** logic/psi_pin_interface.sv ***
/*
 * Pin-level interface of a 16-bit pseudo-static RAM: command decode for
 * asynchronous, NOR-style burst and fully synchronous protocols, byte
 * enables, configuration register access, data bus and wait indicator.
 * Assumes every pin input, the host clock among them, is synchronous to
 * core_clk, and that core_clk runs well above the host clock.
 */
`timescale 1ns/10ps
`include "psi_params.svh"

// Summary of operation
// - Synchronous burst: address, command, write data taken on host clock rise.
// - Register select high steers the access to the control registers.
// - Set-configuration loads the address bus into the selected register.
// - Fetch-configuration drives the selected register onto the data pins.
// - Address-valid strobe low marks a valid address in burst modes.
// - Burst read address latched on the clock edge while strobe low.
// - NOR write accepts a pulsed or a held-low address strobe.
// - Command decoder works only while chip select is low.
// - Deselected: commands ignored, address don't-care, outputs high-Z.
// - An asynchronous write already running completes after deselect; a burst stops.
// - Data pins driven only while output enable is low.
// - Outside synchronous mode, write starts when write strobe and chip select are both low.
// - Byte enables gate their data byte on reads and writes.
// - In synchronous mode WAIT shows when data is valid or expected.
// - Write bursts use fixed latency; host need not watch WAIT.
// - Register set takes its value from the address inputs.
// - Data moves over a 16-bit bidirectional bus.
// - After reset the device runs the asynchronous protocol.
module psi_pin_interface
(
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic                 host_clk,
    input  wire logic                 cs_n,
    input  wire logic                 we_n,
    input  wire logic                 oe_n,
    input  wire logic                 address_valid_strobe_n,
    input  wire logic                 register_map_select,
    input  wire logic                 upper_byte_enable_n,
    input  wire logic                 lower_byte_enable_n,
    input  wire logic [`PSI_AW-1:0]   addr,
    input  wire logic [`PSI_DW-1:0]   dq_in,
    output logic      [`PSI_DW-1:0]   dq_out,
    output logic      [1:0]           dq_oe_n,
    output logic                      wait_out,
    output logic                      wait_oe_n
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    psi_pkg::psi_state_type state_q;
    psi_pkg::psi_state_type state_d;
    psi_pkg::psi_mode_type  mode;
    logic                   host_clk_q;
    logic [`PSI_LAT_W-1:0]  lat_cnt_q;
    logic [`PSI_LAT_W-1:0]  lat_cnt_d;
    logic [`PSI_AW-1:0]     burst_addr_q;
    logic [`PSI_AW-1:0]     burst_addr_d;
    logic [`PSI_AW-1:0]     wr_addr_q;
    logic [`PSI_DW-1:0]     wr_data_q;
    logic [1:0]             wr_be_n_q;
    logic [`PSI_DW-1:0]     dq_out_q;
    logic [1:0]             dq_oe_n_q;
    logic                   wait_q;
    logic                   wait_oe_n_q;
    logic [`PSI_DW-1:0]     bcr;
    logic [`PSI_DW-1:0]     cfg_rdata;
    logic [`PSI_DW-1:0]     mem_rdata;
    logic [1:0]             mem_wr_bytes;
    logic [`PSI_AW-1:0]     mem_wr_addr;
    logic [`PSI_DW-1:0]     mem_wr_data;
    logic [`PSI_AW-1:0]     mem_rd_addr;
    logic [1:0]             byte_en_n;
    logic                   host_rise;
    logic                   cmd_en;
    logic                   idle;
    logic                   mode_async;
    logic                   mode_sync;
    logic                   cfg_set;
    logic                   cfg_fetch;
    logic                   cfg_load;
    logic                   sync_start;
    logic                   async_wr;
    logic                   async_rd;
    logic                   beat;
    logic                   awr_commit;
    logic                   bwr_beat;
    logic                   wr_capture;
    logic                   drive_ok;
    logic                   in_write;

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    // Decoder gated by chip select; no new command is taken from idle while it is high
    assign cmd_en     = !cs_n;
    assign idle       = (state_q == psi_pkg::ST_IDLE);
    assign mode       = psi_pkg::psi_mode_type'(bcr[`PSI_MODE_MSB:`PSI_MODE_LSB]);
    assign mode_async = (mode == psi_pkg::MODE_ASYNC) || (mode == psi_pkg::MODE_RSVD);
    assign mode_sync  = (mode == psi_pkg::MODE_SYNC);
    assign host_rise  = host_clk && !host_clk_q;
    assign byte_en_n  = {upper_byte_enable_n, lower_byte_enable_n};

    // Register select diverts both directions away from the array
    assign cfg_set    = register_map_select && !we_n && !address_valid_strobe_n;
    assign cfg_fetch  = register_map_select && we_n && !oe_n;
    assign cfg_load   = idle && cmd_en && cfg_set;
    // Burst start needs the strobe low on a host clock rise
    assign sync_start = !mode_async && host_rise && !address_valid_strobe_n
                        && !register_map_select && (we_n || mode_sync);
    // NOR mode writes stay asynchronous
    assign async_wr   = !register_map_select && !we_n && !mode_sync;
    assign async_rd   = !register_map_select && we_n && !oe_n && mode_async;

    // Burst beat: one data word per host clock rise once latency is spent
    assign beat       = host_rise && !cs_n && address_valid_strobe_n && (lat_cnt_q == '0);
    assign bwr_beat   = (state_q == psi_pkg::ST_BWR) && beat;
    // A started asynchronous write completes even if chip select leaves
    assign awr_commit = (state_q == psi_pkg::ST_AWR) && (we_n || cs_n);
    assign wr_capture = !we_n && !cs_n && (idle ? async_wr && !cfg_set : state_q == psi_pkg::ST_AWR);
    assign in_write   = (state_q == psi_pkg::ST_AWR) || (state_q == psi_pkg::ST_BWR)
                        || (state_q == psi_pkg::ST_CWR);

    // ------------------------------------------------------------------------
    // Memory port selection
    // ------------------------------------------------------------------------
    // Masked bytes never reach the array
    assign mem_wr_bytes = awr_commit ? ~wr_be_n_q : (bwr_beat ? ~byte_en_n : 2'h0);
    assign mem_wr_addr  = awr_commit ? wr_addr_q : burst_addr_q;
    assign mem_wr_data  = awr_commit ? wr_data_q : dq_in;
    assign mem_rd_addr  = (state_q == psi_pkg::ST_BRD) ? burst_addr_q : addr;
    assign drive_ok     = cmd_en && !oe_n && we_n && !in_write;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_d      = state_q;
        lat_cnt_d    = lat_cnt_q;
        burst_addr_d = burst_addr_q;
        case (state_q)
            psi_pkg::ST_IDLE:
            begin
                if (cmd_en)
                begin
                    if (cfg_set)
                        state_d = psi_pkg::ST_CWR;
                    else if (sync_start)
                    begin
                        state_d      = (!we_n) ? psi_pkg::ST_BWR : psi_pkg::ST_BRD;
                        lat_cnt_d    = `PSI_BURST_LATENCY;
                        burst_addr_d = addr;
                    end
                    else if (async_wr)
                        state_d = psi_pkg::ST_AWR;
                    else if (async_rd)
                        state_d = psi_pkg::ST_ARD;
                end
            end
            psi_pkg::ST_AWR, psi_pkg::ST_CWR:
            begin
                if (we_n || cs_n)
                    state_d = psi_pkg::ST_IDLE;
            end
            psi_pkg::ST_ARD:
            begin
                if (cs_n || oe_n)
                    state_d = psi_pkg::ST_IDLE;
            end
            psi_pkg::ST_BRD, psi_pkg::ST_BWR:
            begin
                if (cs_n)
                    state_d = psi_pkg::ST_IDLE;
                else if (host_rise && !address_valid_strobe_n)
                begin
                    lat_cnt_d    = `PSI_BURST_LATENCY;
                    burst_addr_d = addr;
                end
                else if (host_rise && lat_cnt_q != '0)
                    lat_cnt_d = lat_cnt_q - 1'b1;
                else if (beat)
                    burst_addr_d = burst_addr_q + 1'b1;
            end
            default:
                state_d = psi_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // State and burst registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q      <= psi_pkg::ST_IDLE;
            lat_cnt_q    <= '0;
            burst_addr_q <= '0;
            host_clk_q   <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            lat_cnt_q    <= lat_cnt_d;
            burst_addr_q <= burst_addr_d;
            host_clk_q   <= host_clk;
        end
    end

    // Asynchronous write holder; the address follows a low strobe, so a pulse
    // or a held-low strobe both leave the right address behind
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_addr_q <= '0;
            wr_data_q <= '0;
            wr_be_n_q <= 2'h3;
        end
        else
        begin
            if (!address_valid_strobe_n && (idle || state_q == psi_pkg::ST_AWR))
                wr_addr_q <= addr;
            if (wr_capture)
            begin
                wr_data_q <= dq_in;
                wr_be_n_q <= byte_en_n;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin outputs, all from flops
    // ------------------------------------------------------------------------
    // Deselect or raised output enable float the bus; WAIT floats outside
    // the burst protocols since the host ignores it there
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dq_out_q    <= '0;
            dq_oe_n_q   <= 2'h3;
            wait_q      <= 1'b0;
            wait_oe_n_q <= 1'b1;
        end
        else
        begin
            dq_out_q    <= register_map_select ? cfg_rdata : mem_rdata;
            dq_oe_n_q   <= drive_ok ? byte_en_n : 2'h3;
            wait_q      <= (state_q == psi_pkg::ST_BRD || state_q == psi_pkg::ST_BWR) && (lat_cnt_q != '0);
            wait_oe_n_q <= cs_n || mode_async;
        end
    end

    assign dq_out    = dq_out_q;
    assign dq_oe_n   = dq_oe_n_q;
    assign wait_out  = wait_q;
    assign wait_oe_n = wait_oe_n_q;

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    psi_cfg_regs u_cfg
    (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .load     (cfg_load),
        .addr     (addr),
        .rd_data  (cfg_rdata),
        .bcr      (bcr)
    );

    psi_mem u_mem
    (
        .core_clk (core_clk),
        .wr_bytes (mem_wr_bytes),
        .wr_addr  (mem_wr_addr),
        .wr_data  (mem_wr_data),
        .rd_addr  (mem_rd_addr),
        .rd_data  (mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    a_deselect_hiz: assert property (cs_n |=> dq_oe_n_q == 2'h3 && wait_oe_n_q)
        else $error("Outputs driven while deselected");
    a_oe_gates_dq: assert property (oe_n |=> dq_oe_n_q == 2'h3)
        else $error("Data driven while output enable high");
    a_upper_byte_gate: assert property (upper_byte_enable_n |=> dq_oe_n_q[1])
        else $error("Upper byte driven while disabled");
    a_decoder_off: assert property (idle && cs_n |=> state_q == psi_pkg::ST_IDLE)
        else $error("Command taken while deselected");
    a_write_start: assert property (idle && !cs_n && !we_n && !register_map_select && !mode_sync
                                    |=> state_q == psi_pkg::ST_AWR)
        else $error("Write command not started");
    a_cfg_fetch: assert property (idle && !cs_n && cfg_fetch |=> dq_out_q == $past(cfg_rdata))
        else $error("Fetched register not on data bus");
    a_cfg_load: assert property (cfg_load && addr[`PSI_SEL_BCR_BIT] && !addr[`PSI_SEL_ID_BIT]
                                 |=> bcr == $past(addr[`PSI_CFG_LOAD_MSB:0]))
        else $error("Bus configuration not loaded from address");
    a_burst_addr_latch: assert property (idle && !cs_n && sync_start && !register_map_select
                                         |=> burst_addr_q == $past(addr))
        else $error("Burst address not latched");
    a_inflight_done: assert property (state_q == psi_pkg::ST_AWR && cs_n
                                      |-> mem_wr_bytes == ~wr_be_n_q ##1 idle)
        else $error("Write in flight dropped on deselect");
    a_wait_latency: assert property (state_q == psi_pkg::ST_BRD && lat_cnt_q != '0 |=> wait_q)
        else $error("WAIT low during latency");
    a_fixed_latency: assert property (idle && !cs_n && sync_start && !we_n |=> lat_cnt_q == `PSI_BURST_LATENCY)
        else $error("Write burst latency not fixed");

    c_async_write: cover property (state_q == psi_pkg::ST_AWR ##1 idle);
    c_cfg_set: cover property (cfg_load);
    c_burst_read: cover property (state_q == psi_pkg::ST_BRD && beat);
    c_burst_write: cover property (bwr_beat);

endmodule

// *** tb/psi_host_model.sv ***
/*
 * Host model: drives every pin of the pin interface and resolves the data bus.
 * Assumes the bench calls its tasks and steps its clock right after core_clk rises.
 */
`timescale 1ns/10ps
`include "psi_params.svh"

module psi_host_model
(
    input  wire logic                 core_clk,
    input  wire logic [`PSI_DW-1:0]   dq_out,
    input  wire logic [1:0]           dq_oe_n,
    output logic                      host_clk,
    output logic                      cs_n,
    output logic                      we_n,
    output logic                      oe_n,
    output logic                      address_valid_strobe_n,
    output logic                      register_map_select,
    output logic                      upper_byte_enable_n,
    output logic                      lower_byte_enable_n,
    output logic      [`PSI_AW-1:0]   addr,
    output logic      [`PSI_DW-1:0]   dq_in
);
    logic [`PSI_DW-1:0] host_val;
    logic [`PSI_DW-1:0] idle_pat;
    logic               drive_on;

    // Released bus shows a toggling pattern, so a stale value never passes
    always @(posedge core_clk)
        idle_pat <= ~idle_pat;
    assign dq_in = {!dq_oe_n[1] ? dq_out[15:8] : (drive_on ? host_val[15:8] : idle_pat[15:8]),
                    !dq_oe_n[0] ? dq_out[7:0] : (drive_on ? host_val[7:0] : idle_pat[7:0])};

    // Idle pins; strobe tied low for the asynchronous protocol
    initial
    begin
        idle_pat = 16'h5a5a;
        host_clk = 1'b0;
        pins(1, 1, 1, 0, 0, 1, 1, 22'h000000, 16'h0000, 0);
    end

    // Wait n core edges and land just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Set all control pins at once; the bench calls this both between and during operations
    task automatic pins(input logic c, w, o, s, r, u, l, input logic [21:0] a, input logic [15:0] d,
                        input logic dr);
        cs_n = c;
        we_n = w;
        oe_n = o;
        address_valid_strobe_n = s;
        register_map_select = r;
        upper_byte_enable_n = u;
        lower_byte_enable_n = l;
        addr = a;
        host_val = d;
        drive_on = dr;
    endtask

    // One host clock period; the clock runs only inside bursts and rests low
    task automatic hrise();
        host_clk = ~host_clk;
        step(4);
        host_clk = ~host_clk;
        step(4);
    endtask
endmodule

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the pin interface: array access, byte enables,
 * deselect, configuration registers and synchronous read and write bursts.
 * Assumes the host model above and the design files on the include path.
 */
`timescale 1ns/10ps
`include "psi_params.svh"

module tb_top;
    logic core_clk;
    logic arst_n;
    logic host_clk, cs_n, we_n, oe_n, strobe_n, sel, ub_n, lb_n, wait_out, wait_oe_n;
    logic [21:0] addr;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    logic [1:0]  dq_oe_n;
    int mismatches = 0;
    int checks = 0;

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    psi_pin_interface DUT (.core_clk(core_clk), .arst_n(arst_n), .host_clk(host_clk), .cs_n(cs_n),
        .we_n(we_n), .oe_n(oe_n), .address_valid_strobe_n(strobe_n), .register_map_select(sel),
        .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wait_out(wait_out), .wait_oe_n(wait_oe_n));

    psi_host_model u_host (.core_clk(core_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .host_clk(host_clk),
        .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .address_valid_strobe_n(strobe_n),
        .register_map_select(sel), .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n),
        .addr(addr), .dq_in(dq_in));

    // ------------------------------------------------------------------------
    // Compare and bus helpers
    // ------------------------------------------------------------------------
    task automatic chk_data(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_ctl(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Deselect everything and let the device settle
    task automatic park();
        u_host.pins(1, 1, 1, 0, 0, 1, 1, 22'h000000, 16'h0000, 0);
        u_host.step(3);
    endtask

    // Asynchronous write; the write strobe rises before chip select
    task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic u, input logic l);
        u_host.pins(0, 0, 1, 0, 0, u, l, a, d, 1);
        u_host.step(3);
        u_host.pins(0, 1, 1, 0, 0, 1, 1, a, d, 0);
        u_host.step(2);
        park();
    endtask

    // Asynchronous read; only the enabled bytes are judged
    task automatic rd(input logic [21:0] a, input logic u, input logic l, input logic [15:0] exp);
        logic [15:0] m;
        m = {{8{!u}}, {8{!l}}};
        u_host.pins(0, 1, 0, 0, 0, u, l, a, 16'h0000, 0);
        u_host.step(3);
        chk_ctl("dq_oe_n", {u, l}, dq_oe_n);
        chk_data("dq_out", exp & m, dq_out & m);
        park();
        chk_ctl("dq_oe_n idle", 2'h3, dq_oe_n);
    endtask

    // Register set from the address bus if set is high, then fetch the register back
    task automatic cfg(input logic [21:0] a, input logic [15:0] exp, input logic set);
        if (set)
        begin
            u_host.pins(0, 0, 1, 0, 1, 1, 1, a, 16'h0000, 0);
            u_host.step(2);
            park();
        end
        u_host.pins(0, 1, 0, 0, 1, 0, 0, a, 16'h0000, 0);
        u_host.step(2);
        chk_data("cfg word", exp, dq_out);
        park();
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        chk_ctl("reset dq_oe_n", 2'h3, dq_oe_n);
        chk_ctl("reset wait_oe_n", 2'h1, {1'b0, wait_oe_n});
        arst_n = 1'b1;
        u_host.step(2);
        cfg(22'h080000, `PSI_BCR_RESET, 0);
    endtask

    task automatic t_bytes();
        wr(22'h000010, 16'h1234, 0, 0);
        wr(22'h000010, 16'hab00, 0, 1);
        rd(22'h000010, 0, 0, 16'hab34);
        rd(22'h000010, 1, 0, 16'h0034);
    endtask

    task automatic t_deselect();
        u_host.pins(1, 0, 0, 0, 0, 0, 0, 22'h000010, 16'hffff, 1);
        u_host.step(3);
        chk_ctl("deselect oe", 2'h3, dq_oe_n);
        park();
        rd(22'h000010, 0, 0, 16'hab34);
        u_host.pins(0, 0, 1, 0, 0, 0, 0, 22'h000011, 16'h5678, 1);
        u_host.step(3);
        u_host.pins(1, 0, 1, 0, 0, 0, 0, 22'h000011, 16'h5678, 1);
        u_host.step(2);
        park();
        rd(22'h000011, 0, 0, 16'h5678);
    endtask

    task automatic t_config();
        cfg(22'h000abc, 16'h0abc, 1);
        cfg(22'h040000, `PSI_DEVICE_ID, 0);
        cfg(22'h080002, 16'h0002, 1);
    endtask

    task automatic t_burst();
        u_host.pins(0, 1, 0, 0, 0, 0, 0, 22'h000010, 16'h0000, 0);
        u_host.hrise();
        u_host.pins(0, 1, 0, 1, 0, 0, 0, 22'h3fffff, 16'h0000, 0);
        u_host.hrise();
        u_host.hrise();
        chk_ctl("wait latency", 2'h1, {1'b0, wait_out});
        u_host.hrise();
        chk_ctl("wait ready", 2'h0, {1'b0, wait_out});
        chk_ctl("wait drive", 2'h0, {1'b0, wait_oe_n});
        chk_data("burst word 0", 16'hab34, dq_out);
        u_host.hrise();
        chk_data("burst word 1", 16'h5678, dq_out);
        park();
    endtask

    // Write burst of one upper-byte word, then back to the asynchronous protocol to read it
    task automatic t_wburst();
        u_host.pins(0, 0, 1, 0, 0, 0, 1, 22'h000020, 16'hc3c3, 1);
        u_host.hrise();
        u_host.pins(0, 0, 1, 1, 0, 0, 1, 22'h3fffff, 16'hc3c3, 1);
        repeat (4) u_host.hrise();
        park();
        cfg(22'h080000, 16'h0000, 1);
        rd(22'h000020, 0, 1, 16'hc300);
    endtask

    // ------------------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // ------------------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        arst_n = 1'b0;
        u_host.step(20);
        t_reset();
        t_bytes();
        t_deselect();
        t_config();
        t_burst();
        t_wburst();
        results();
    end

    // Whole run is a few hundred cycles; far beyond that means a hang
    initial
    begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        results();
    end
endmodule
